// ### ts_framer_pkg.sv
// package: bus map, field layouts and state types of the stream input framer
package ts_framer_pkg;
  // register map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CFG_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] TBL_OFS = 12'h800;
  localparam int TBL_SEL_BIT = 11;
  localparam int ENTRY_LO = 3;
  localparam int ENTRY_HI = 10;
  localparam int WORD_BIT = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CFG_RST = 32'h0000_BC47;
  // control word fields
  localparam int CTRL_HOLD = 0;
  localparam int CTRL_SERIAL = 1;
  localparam int CTRL_LSB = 2;
  localparam int CTRL_FALL = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_WIN = 6;
  localparam int CTRL_LOOP = 7;
  // configuration word fields
  localparam int CFG_SYNC_LO = 0;
  localparam int CFG_SIZE_LO = 8;
  localparam int CFG_TAG_LO = 16;
  localparam int CFG_START_LO = 24;
  // framing modes
  localparam logic [1:0] MODE_START = 2'h0;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] MODE_VALID = 2'h2;
  localparam logic [1:0] MODE_SEARCH = 2'h3;
  // counts and positions
  localparam int STC_W = 42;
  localparam int TBL_DEPTH = 256;
  localparam int BUF_DEPTH = 512;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ONE = 3'h1;
  localparam logic [2:0] INFO_LAST = 3'h7;
  localparam logic [3:0] WIN_ONE = 4'h1;
  localparam logic [3:0] WIN_BITS = 4'h8;
  localparam logic [3:0] WIN_SAT = 4'hF;
  localparam logic [7:0] WALK_MAX = 8'hFF;
  localparam logic [7:0] PID_HI_IDX = 8'h01;
  localparam logic [7:0] PID_LO_IDX = 8'h02;

  // one filter table entry, two words, upper word first
  typedef struct packed {
    logic [15:0] rsv2;
    logic [7:0] match_tag;
    logic [7:0] next_addr;
    logic [2:0] rsv1;
    logic [12:0] pid;
    logic [7:0] stream_tag;
    logic [2:0] rsv0;
    logic counter_sel;
    logic cmp_pid;
    logic cmp_tag;
    logic active;
    logic end_of_list;
  } table_entry_type;

  // eight-byte record appended to each kept packet
  typedef struct packed {
    logic pkt_dropped;
    logic data_lost;
    logic data_dropped;
    logic under_sized;
    logic bad_sync;
    logic port_err;
    logic async_err;
    logic rsv1;
    logic [7:0] match_tag;
    logic [5:0] rsv0;
    logic [STC_W-1:0] stc;
  } packet_info_type;

  typedef enum logic [2:0] {F_IDLE = 3'b001, F_WALK = 3'b010, F_DONE = 3'b100} filter_state_type;
  typedef enum logic [2:0] {D_IDLE = 3'b001, D_BODY = 3'b010, D_INFO = 3'b100} drain_state_type;

  // whole state of the framer
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [31:0] rdata;
    logic ack;
    logic [15:0] kept_cnt;
    logic [15:0] lost_cnt;
    logic lk_s1;
    logic lk_s2;
    logic lk_prev;
    logic [9:0] in_s1;
    logic [9:0] in_s2;
    logic [2:0] ta_s;
    logic [2:0] tb_s;
    logic [STC_W-1:0] stc_a;
    logic [STC_W-1:0] stc_b;
    logic [STC_W-1:0] snap_a;
    logic [STC_W-1:0] snap_b;
    logic valid_prev;
    logic [3:0] rise_bits;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic sflag;
    logic in_pkt;
    logic keep;
    logic [7:0] cnt;
    logic [12:0] pid;
    logic excess;
    logic pend_drop;
    logic f_dropped;
    logic f_under;
    logic f_bad;
    logic f_pktdrop;
    logic wr_half;
    logic [1:0] full;
    logic [1:0] dec;
    logic [1:0] hit;
    packet_info_type [1:0] info;
    filter_state_type fstate;
    logic fhalf;
    logic [7:0] faddr;
    logic [7:0] fsteps;
    logic [7:0] ftag;
    logic fhit;
    logic fsel;
    drain_state_type dstate;
    logic rd_half;
    logic [7:0] rd_idx;
    logic out_valid;
    logic out_last;
    logic [7:0] out_data;
  } framer_state_type;
endpackage

// ### ts_input_framer.sv
// transport stream input framer with table-driven packet filter
`timescale 1ns/100ps
`default_nettype none

module ts_input_framer
  import ts_framer_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic stream_clock,
  input wire logic packet_sync_strobe,
  input wire logic byte_valid_strobe,
  input wire logic [7:0] stream_data,
  input wire logic timestamp_clock_a,
  input wire logic timestamp_clock_b,
  input wire logic loop_valid,
  input wire logic loop_start,
  input wire logic [7:0] loop_data,
  output logic loop_ready,
  output logic pkt_valid,
  output logic [7:0] pkt_data,
  output logic pkt_last,
  input wire logic pkt_ready
);

  localparam framer_state_type STATE_RST = '{ctrl: CTRL_RST, cfg: CFG_RST, fstate: F_IDLE,
                                             dstate: D_IDLE, default: '0};

  // byte-lane merge for bus writes
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  framer_state_type st, n;
  logic [63:0] table_mem [0:TBL_DEPTH-1];
  logic [7:0] pkt_mem [0:BUF_DEPTH-1];

  logic hold, serial, lsb, loop_on, win_opt;
  logic [1:0] mode;
  logic [7:0] sync_val, pkt_size, tag_val, tbl_start;
  logic bus_req, bus_do, tbl_sel;
  logic [7:0] bus_entry;
  logic [63:0] bus_ent, bus_ent_new;
  logic ts_edge, in_sync, in_valid, rise, win_ok;
  logic [7:0] in_data;
  logic byte_done, byte_start, bits_lost;
  logic [7:0] byte_val, sh_nxt;
  logic [2:0] bitcnt_nxt;
  logic [3:0] rbits_nxt;
  logic new_pkt, data_byte, keep_now, pkt_end;
  logic pkt_we;
  logic [8:0] pkt_waddr;
  table_entry_type cur_ent;
  logic ent_hit;
  logic slot_free;

  // configuration views
  assign hold = st.ctrl[CTRL_HOLD];
  assign serial = st.ctrl[CTRL_SERIAL];
  assign lsb = st.ctrl[CTRL_LSB];
  assign mode = st.ctrl[CTRL_MODE_LO +: 2];
  assign win_opt = st.ctrl[CTRL_WIN];
  assign loop_on = st.ctrl[CTRL_LOOP];
  assign sync_val = st.cfg[CFG_SYNC_LO +: 8];
  assign pkt_size = st.cfg[CFG_SIZE_LO +: 8];
  assign tag_val = st.cfg[CFG_TAG_LO +: 8];
  assign tbl_start = st.cfg[CFG_START_LO +: 8];

  // bus decode: every access waits one cycle, then completes
  assign bus_req = read | write;
  assign bus_do = bus_req & st.ack;
  assign waitrequest = bus_req & ~st.ack;
  assign tbl_sel = address[TBL_SEL_BIT];
  assign bus_entry = address[ENTRY_HI:ENTRY_LO];
  assign bus_ent = table_mem[bus_entry];
  assign readdata = st.rdata;

  // outputs
  assign pkt_valid = st.out_valid;
  assign pkt_data = st.out_data;
  assign pkt_last = st.out_last;
  assign loop_ready = loop_on & ~hold & ~st.full[st.wr_half];

  // stream clock edge, taken from the resynchronised copy
  assign ts_edge = (st.lk_s2 != st.lk_prev) && (st.lk_s2 == ~st.ctrl[CTRL_FALL]);
  assign in_sync = st.in_s2[9];
  assign in_valid = st.in_s2[8];
  assign in_data = st.in_s2[7:0];
  assign rise = in_valid & ~st.valid_prev;

  // table entry under the walk pointer and its compare
  assign cur_ent = table_entry_type'(table_mem[st.faddr]);
  assign ent_hit = cur_ent.active && (!cur_ent.cmp_tag || cur_ent.stream_tag == tag_val)
                   && (!cur_ent.cmp_pid || cur_ent.pid == st.pid);

  // table write lane merge
  always_comb begin
    bus_ent_new = bus_ent;
    if (address[WORD_BIT]) begin
      bus_ent_new[63:32] = merge_be(bus_ent[63:32], writedata, byteenable);
    end else begin
      bus_ent_new[31:0] = merge_be(bus_ent[31:0], writedata, byteenable);
    end
  end

  // front end: turns sampled bits or bytes into bytes with a start mark
  always_comb begin
    sh_nxt = st.shreg;
    bitcnt_nxt = st.bitcnt;
    rbits_nxt = st.rise_bits;
    byte_done = 1'b0;
    byte_start = 1'b0;
    byte_val = in_data;
    bits_lost = 1'b0;
    win_ok = 1'b1;
    if (hold) begin
      bitcnt_nxt = 3'h0;
    end else if (loop_on) begin
      byte_done = loop_valid & loop_ready;
      byte_start = loop_start;
      byte_val = loop_data;
    end else if (ts_edge && in_valid) begin
      rbits_nxt = rise ? WIN_ONE : ((st.rise_bits == WIN_SAT) ? WIN_SAT : st.rise_bits + WIN_ONE);
      win_ok = !win_opt || (serial ? rbits_nxt == WIN_BITS : rise);
      if (!serial) begin
        byte_done = 1'b1;
        case (mode)
          MODE_START, MODE_SYNC: byte_start = in_sync;
          MODE_VALID: byte_start = rise;
          default: byte_start = !st.in_pkt && in_data == sync_val && win_ok;
        endcase
      end else begin
        sh_nxt = lsb ? {in_data[0], st.shreg[7:1]} : {st.shreg[6:0], in_data[0]};
        byte_val = sh_nxt;
        if (mode == MODE_SEARCH) begin
          bitcnt_nxt = st.bitcnt + BIT_ONE;
          if (!st.in_pkt) begin
            if (sh_nxt == sync_val && win_ok) begin
              byte_done = 1'b1;
              byte_start = 1'b1;
              bitcnt_nxt = 3'h0;
            end else begin
              bits_lost = st.bitcnt == BIT_LAST;
            end
          end else begin
            byte_done = st.bitcnt == BIT_LAST;
          end
        end else if ((mode == MODE_VALID) ? rise : in_sync) begin
          bits_lost = st.bitcnt != 3'h0;
          bitcnt_nxt = BIT_ONE;
        end else begin
          bitcnt_nxt = st.bitcnt + BIT_ONE;
          byte_done = st.bitcnt == BIT_LAST;
          byte_start = st.sflag;
        end
      end
    end
  end

  // byte classification
  assign new_pkt = byte_done && byte_start && !st.in_pkt;
  assign data_byte = byte_done && st.in_pkt;
  assign keep_now = loop_on || !st.full[st.wr_half];
  assign pkt_end = data_byte && (8'(st.cnt + 8'h01) == pkt_size);
  assign pkt_we = (new_pkt && keep_now) || (data_byte && st.keep);
  assign pkt_waddr = {st.wr_half, new_pkt ? 8'h00 : st.cnt};
  assign slot_free = !st.out_valid || pkt_ready;

  // next state of the whole framer
  always_comb begin
    n = st;
    // resynchronisers for the stream pins and stamp clocks
    n.lk_s1 = stream_clock;
    n.lk_s2 = st.lk_s1;
    n.lk_prev = st.lk_s2;
    n.in_s1 = {packet_sync_strobe, byte_valid_strobe, stream_data};
    n.in_s2 = st.in_s1;
    n.ta_s = {st.ta_s[1], st.ta_s[0], timestamp_clock_a};
    n.tb_s = {st.tb_s[1], st.tb_s[0], timestamp_clock_b};
    if (st.ta_s[1] && !st.ta_s[2]) begin
      n.stc_a = st.stc_a + 42'h1;
    end
    if (st.tb_s[1] && !st.tb_s[2]) begin
      n.stc_b = st.stc_b + 42'h1;
    end
    // bus slave
    n.ack = bus_req && !st.ack;
    if (bus_req && !st.ack) begin
      if (tbl_sel) begin
        n.rdata = address[WORD_BIT] ? bus_ent[63:32] : bus_ent[31:0];
      end else begin
        case (address)
          CTRL_OFS: n.rdata = st.ctrl;
          CFG_OFS: n.rdata = st.cfg;
          STAT_OFS: n.rdata = {st.lost_cnt, st.kept_cnt};
          default: n.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (write && bus_do && !tbl_sel) begin
      if (address == CTRL_OFS) begin
        n.ctrl = merge_be(st.ctrl, writedata, byteenable);
      end
      if (address == CFG_OFS) begin
        n.cfg = merge_be(st.cfg, writedata, byteenable);
      end
    end
    // bit assembly
    n.shreg = sh_nxt;
    n.bitcnt = bitcnt_nxt;
    n.rise_bits = rbits_nxt;
    if (ts_edge) begin
      n.valid_prev = in_valid;
    end
    if (ts_edge && in_valid && serial && mode != MODE_SEARCH) begin
      n.sflag = ((mode == MODE_VALID) ? rise : in_sync) || (st.sflag && !byte_done);
    end
    // surplus bits or bytes outside a packet
    if (bits_lost || (byte_done && !st.in_pkt && !byte_start)) begin
      n.excess = 1'b1;
    end
    // first byte of a packet
    if (new_pkt) begin
      n.in_pkt = 1'b1;
      n.cnt = 8'h01;
      n.keep = keep_now;
      n.snap_a = st.stc_a;
      n.snap_b = st.stc_b;
      n.f_bad = byte_val != sync_val;
      n.f_under = 1'b0;
      n.f_dropped = st.excess | bits_lost;
      n.excess = 1'b0;
      if (keep_now) begin
        n.f_pktdrop = st.pend_drop;
        n.pend_drop = 1'b0;
      end else begin
        n.pend_drop = 1'b1;
        n.lost_cnt = st.lost_cnt + 16'h0001;
      end
    end
    // following bytes; a start inside a packet merges the two
    if (data_byte) begin
      if (byte_start) begin
        n.f_under = 1'b1;
      end
      n.cnt = st.cnt + 8'h01;
      if (st.cnt == PID_HI_IDX) begin
        n.pid[12:8] = byte_val[4:0];
      end
      if (st.cnt == PID_LO_IDX) begin
        n.pid[7:0] = byte_val;
        if (st.keep) begin
          n.fstate = F_WALK;
          n.faddr = tbl_start;
          n.fsteps = 8'h00;
          n.fhalf = st.wr_half;
        end
      end
      if (pkt_end) begin
        n.in_pkt = 1'b0;
        n.cnt = 8'h00;
        if (st.keep) begin
          n.full[st.wr_half] = 1'b1;
          n.info[st.wr_half].data_dropped = st.f_dropped;
          n.info[st.wr_half].under_sized = st.f_under | byte_start;
          n.info[st.wr_half].bad_sync = st.f_bad;
          n.info[st.wr_half].pkt_dropped = st.f_pktdrop;
          n.info[st.wr_half].data_lost = 1'b0;
          n.info[st.wr_half].port_err = 1'b0;
          n.info[st.wr_half].async_err = 1'b0;
          n.wr_half = ~st.wr_half;
        end
      end
    end
    // table walk
    case (st.fstate)
      F_IDLE: begin
      end
      F_WALK: begin
        if (ent_hit) begin
          n.fhit = 1'b1;
          n.ftag = cur_ent.match_tag;
          n.fsel = cur_ent.counter_sel;
          n.fstate = F_DONE;
        end else if (cur_ent.end_of_list || st.fsteps == WALK_MAX) begin
          n.fhit = 1'b0;
          n.fstate = F_DONE;
        end else begin
          n.faddr = cur_ent.next_addr;
          n.fsteps = st.fsteps + 8'h01;
        end
      end
      F_DONE: begin
        n.hit[st.fhalf] = st.fhit;
        n.dec[st.fhalf] = 1'b1;
        n.info[st.fhalf].match_tag = st.ftag;
        n.info[st.fhalf].stc = st.fsel ? st.snap_b : st.snap_a;
        n.fstate = F_IDLE;
      end
      default: n.fstate = F_IDLE;
    endcase
    // drain toward the packet fifo
    if (slot_free) begin
      n.out_valid = 1'b0;
      n.out_last = 1'b0;
    end
    case (st.dstate)
      D_IDLE: begin
        if (st.full[st.rd_half] && st.dec[st.rd_half]) begin
          if (st.hit[st.rd_half]) begin
            n.dstate = D_BODY;
            n.rd_idx = 8'h00;
          end else begin
            n.full[st.rd_half] = 1'b0;
            n.dec[st.rd_half] = 1'b0;
            n.rd_half = ~st.rd_half;
          end
        end
      end
      D_BODY: begin
        if (slot_free) begin
          n.out_valid = 1'b1;
          n.out_data = pkt_mem[{st.rd_half, st.rd_idx}];
          n.rd_idx = st.rd_idx + 8'h01;
          if (8'(st.rd_idx + 8'h01) == pkt_size) begin
            n.dstate = D_INFO;
            n.rd_idx = 8'h00;
          end
        end
      end
      D_INFO: begin
        if (slot_free) begin
          n.out_valid = 1'b1;
          n.out_data = st.info[st.rd_half][{st.rd_idx[2:0], 3'b000} +: 8];
          n.rd_idx = st.rd_idx + 8'h01;
          if (st.rd_idx[2:0] == INFO_LAST) begin
            n.out_last = 1'b1;
            n.full[st.rd_half] = 1'b0;
            n.dec[st.rd_half] = 1'b0;
            n.rd_half = ~st.rd_half;
            n.kept_cnt = st.kept_cnt + 16'h0001;
            n.dstate = D_IDLE;
          end
        end
      end
      default: n.dstate = D_IDLE;
    endcase
    // held in reset by software: pipeline cleared, configuration kept
    if (hold) begin
      n.in_pkt = 1'b0;
      n.cnt = 8'h00;
      n.keep = 1'b0;
      n.sflag = 1'b0;
      n.excess = 1'b0;
      n.pend_drop = 1'b0;
      n.full = 2'b00;
      n.dec = 2'b00;
      n.hit = 2'b00;
      n.wr_half = 1'b0;
      n.rd_half = 1'b0;
      n.fstate = F_IDLE;
      n.dstate = D_IDLE;
      n.out_valid = 1'b0;
      n.out_last = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= STATE_RST;
    end else begin
      st <= n;
    end
  end

  // shared filter table, written by the bus
  always_ff @(posedge clk) begin
    if (write && bus_do && tbl_sel) begin
      table_mem[bus_entry] <= bus_ent_new;
    end
  end

  // two-packet buffer holding bytes until the filter decides
  always_ff @(posedge clk) begin
    if (pkt_we) begin
      pkt_mem[pkt_waddr] <= byte_val;
    end
  end

  // checks
  edge_select_a: assert property (@(posedge clk) disable iff (!resetn)
    ts_edge |-> $past(stream_clock, 2) != $past(stream_clock, 3) && $past(stream_clock, 2) != st.ctrl[CTRL_FALL])
    else $error("stream edge taken on the wrong polarity");
  resync_chain_a: assert property (@(posedge clk) disable iff (!resetn)
    ##2 st.in_s2 == $past({packet_sync_strobe, byte_valid_strobe, stream_data}, 2))
    else $error("stream lines not delayed by two stages");
  search_skip_a: assert property (@(posedge clk) disable iff (!resetn)
    (new_pkt && mode == MODE_SEARCH && !hold) |=> st.in_pkt && st.cnt == 8'h01)
    else $error("search did not enter the skip window");
  bad_sync_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (new_pkt && byte_val != sync_val && !hold) |=> st.f_bad)
    else $error("wrong sync byte not flagged");
  short_merge_a: assert property (@(posedge clk) disable iff (!resetn)
    (data_byte && byte_start && !pkt_end && !hold) |=> st.in_pkt && st.f_under && st.cnt == $past(st.cnt) + 8'h01)
    else $error("short packet not merged");
  excess_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (new_pkt && st.excess && !hold) |=> st.f_dropped && !st.excess)
    else $error("surplus data not flagged on next packet");
  walk_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    (st.fstate == F_WALK && ent_hit && !hold) |=> st.fstate == F_DONE && st.fhit
      && st.ftag == $past(cur_ent.match_tag))
    else $error("walk did not stop on first match");
  walk_follow_a: assert property (@(posedge clk) disable iff (!resetn)
    (st.fstate == F_WALK && !ent_hit && !cur_ent.end_of_list && st.fsteps != WALK_MAX && !hold)
      |=> st.fstate == F_WALK && st.faddr == $past(cur_ent.next_addr))
    else $error("walk did not follow the next address");
  miss_drop_a: assert property (@(posedge clk) disable iff (!resetn)
    (st.dstate == D_IDLE && st.full[st.rd_half] && st.dec[st.rd_half] && !st.hit[st.rd_half] && !hold)
      |=> st.dstate == D_IDLE && st.rd_half != $past(st.rd_half) && !st.full[$past(st.rd_half)])
    else $error("unmatched packet not discarded");
  stamp_pick_a: assert property (@(posedge clk) disable iff (!resetn)
    (st.fstate == F_DONE && !hold) |=> st.info[$past(st.fhalf)].stc == ($past(st.fsel) ? $past(st.snap_b)
      : $past(st.snap_a)))
    else $error("wrong stamp counter captured");

endmodule
`default_nettype wire

// ### ts_source.sv
// stream source model: parallel bytes or serial bits, one link clock period each
`timescale 1ns/100ps
`default_nettype none
module ts_source (
  input wire logic clk,
  output logic stream_clock,
  output logic sync_o,
  output logic valid_o,
  output logic [7:0] data_o
);
  // lines start idle and low
  initial begin
    stream_clock = 1'b0;
    sync_o = 1'b0;
    valid_o = 1'b0;
    data_o = 8'h00;
  end
  // one 225 ns link period: lines change, rise after four core cycles, fall after eight
  task automatic period(input logic [7:0] b, input logic first, input logic v);
    @(posedge clk);
    data_o <= b;
    sync_o <= first;
    valid_o <= v;
    repeat (4) @(posedge clk);
    stream_clock <= 1'b1;
    repeat (4) @(posedge clk);
    stream_clock <= 1'b0;
  endtask
  // one parallel byte
  task automatic send_byte(input logic [7:0] b, input logic first);
    period(b, first, 1'b1);
  endtask
  // serial byte: eight periods, bit 0 of the data lines carries each bit
  task automatic send_bits(input logic [7:0] b, input logic first, input logic lsb_first);
    integer i;
    for (i = 0; i < 8; i++) begin
      period({7'h00, lsb_first ? b[i] : b[7 - i]}, first && i == 0, 1'b1);
    end
  endtask
  // released lines show the inverse byte for one period with valid low, so a valid rise follows
  task automatic idle;
    period(~data_o, 1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// ### ts_input_framer_tb.sv
// self-checking bench for the stream input framer
`timescale 1ns/100ps
`default_nettype none
module ts_input_framer_tb;
  import ts_framer_pkg::*;
  logic clk, resetn, read, write, pkt_ready, waitrequest, pkt_valid, pkt_last, loop_ready;
  logic [ADDR_W-1:0] address;
  logic [31:0] writedata, readdata, rd, r;
  logic [7:0] pkt_data;
  logic [7:0] tick = 8'h00;
  logic [7:0] body [0:7];
  logic loop_valid, loop_start;
  logic [7:0] loop_data;
  logic [1:0] ser = 2'h0;
  wire logic sclk, ssync, svalid;
  wire logic [7:0] sdata;
  integer err_count, cmp_count, seed, m;
  ts_source src (.clk(clk), .stream_clock(sclk), .sync_o(ssync), .valid_o(svalid), .data_o(sdata));
  ts_input_framer dut (.clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .stream_clock(sclk), .packet_sync_strobe(ssync), .byte_valid_strobe(svalid), .stream_data(sdata),
    .timestamp_clock_a(tick[2]), .timestamp_clock_b(tick[4]), .loop_valid(loop_valid), .loop_start(loop_start),
    .loop_data(loop_data), .loop_ready(loop_ready), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
    .pkt_last(pkt_last), .pkt_ready(pkt_ready));
  // core clock and stamp clock source
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) tick <= tick + 8'h01;
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin err_count++; final_report(); end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // one loopback byte, offered until loop_ready is seen high at a rising edge
  task automatic loop_byte(input logic [7:0] b, input logic first);
    integer n;
    n = 0;
    loop_valid <= 1'b1;
    loop_start <= first;
    loop_data <= b;
    do begin @(posedge clk); n++; end while (loop_ready !== 1'b1 && n < 3000);
    if (n >= 3000) begin err_count++; final_report(); end
  endtask
  // one packet: sync byte, identifier, random payload, over the link or the loopback input
  task automatic send(input logic [7:0] s, input logic [12:0] pid);
    integer i;
    body[0] = s;
    body[1] = {3'h0, pid[12:8]};
    body[2] = pid[7:0];
    for (i = 3; i < 8; i++) begin r = $random(seed); body[i] = r[7:0]; end
    for (i = 0; i < 8; i++) begin
      if (ser == 2'h3)
        loop_byte(body[i], i == 0);
      else if (ser != 2'h0)
        src.send_bits(body[i], i == 0, ser[1]);
      else
        src.send_byte(body[i], i == 0);
    end
    if (ser == 2'h3)
      loop_valid <= 1'b0;
    else
      src.idle();
  endtask
  // collect body and info with a randomly stalling sink
  task automatic recv(input logic [7:0] tag, input logic [7:0] flg);
    integer i, n;
    logic [7:0] e;
    for (i = 0; i < 16; i++) begin
      n = 0;
      do begin
        @(posedge clk);
        r = $random(seed);
        pkt_ready <= r[0];
        @(negedge clk);
        n++;
      end while (!(pkt_valid === 1'b1 && pkt_ready === 1'b1) && n < 3000);
      if (n >= 3000) begin err_count++; final_report(); end
      e = i < 8 ? body[i] : i == 14 ? tag : i == 15 ? flg : 8'h00;
      chk({pkt_last, (i > 7 && i < 14) ? 8'h00 : pkt_data}, {i == 15, e});
    end
    @(posedge clk);
    pkt_ready <= 1'b0;
  endtask
  // main sequence
  initial begin
    seed = 76227;
    err_count = 0;
    cmp_count = 0;
    resetn = 1'b0;
    {read, write, pkt_ready, loop_valid, loop_start} = 5'h0;
    loop_data = 8'h00;
    address = 12'h000;
    writedata = 32'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    chk({29'h0, pkt_valid, pkt_last, loop_ready}, 32'h0);
    bus(0, CTRL_OFS, 0);
    chk(rd, CTRL_RST);
    bus(0, CFG_OFS, 0);
    chk(rd, CFG_RST);
    bus(0, 12'h010, 0);
    chk(rd, 32'h0);
    bus(1, CFG_OFS, 32'h0000_0847);
    bus(1, TBL_OFS, 32'h0); // inactive entry still links on
    bus(1, TBL_OFS + 12'h004, 32'h0000_AA01);
    bus(1, TBL_OFS + 12'h008, 32'h0123_001B);
    bus(1, TBL_OFS + 12'h00C, 32'h0000_5C00);
    for (m = 0; m < 5; m++) begin
      bus(1, CTRL_OFS, 32'h1);
      bus(1, CTRL_OFS, {25'h0, m[2], m[2] ? 2'h3 : m[1:0], 4'h0});
      send(8'h47, 13'h0555);
      send(8'h47, 13'h0123);
      recv(8'h5C, 8'h00);
      $display("test mode %0d done", m);
    end
    bus(1, CTRL_OFS, 32'h1);
    bus(1, CTRL_OFS, 32'h0);
    send(8'h48, 13'h0123);
    recv(8'h5C, 8'h08);
    src.send_byte(8'hE1, 1'b0);
    src.idle();
    send(8'h48, 13'h0123);
    recv(8'h5C, 8'h28);
    $display("test errors done");
    for (m = 1; m < 4; m++) begin
      ser = m[1:0];
      bus(1, CTRL_OFS, 32'h1);
      bus(1, CTRL_OFS, m == 1 ? 32'h2 : m == 2 ? 32'hE : 32'h80);
      send(8'h47, 13'h0123);
      recv(8'h5C, 8'h00);
      $display("test link %0d done", m);
    end
    bus(0, STAT_OFS, 0);
    chk(rd, 32'h0000_000A);
    final_report();
  end
endmodule
`default_nettype wire
